/* common/wdt_sleep_pkg.sv */
package wdt_sleep_pkg;

    // ***************************************************************
    // option register layout
    // ***************************************************************
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam int SCALER_ASSIGN_POS = 3;
    localparam int RATIO_LSB_POS = 0;
    localparam int RATIO_WIDTH = 3;

    // ***************************************************************
    // fuse word layout
    // ***************************************************************
    localparam int FUSE_WDT_EN_POS = 2;

    // ***************************************************************
    // register offsets on the plain port (chosen here)
    // ***************************************************************
    localparam logic [3:0] ADDR_OPTION = 4'h0;
    localparam logic [3:0] ADDR_FUSE = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_WAKE_EN = 4'h3;

    // status register bits
    localparam int STAT_PD_POS = 0;
    localparam int STAT_TO_POS = 1;
    localparam int STAT_SLEEP_POS = 2;
    localparam int STAT_WDT_RST_POS = 3;

    // wake enable bits: ext int, port change, 16-bit timer, capture, converter
    localparam int WAKE_SRC_COUNT = 5;
    localparam logic [4:0] WAKE_EN_RESET = 5'h00;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int WDT_BASE_COUNT = 18;
    localparam int SCALER_WIDTH = 8;
    localparam int RESET_PULSE_CYCLES = 4;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10
    } power_state_t;

endpackage : wdt_sleep_pkg

/* rtl/watchdog_sleep_wake_ctrl.sv */
// How it works
// R1 - watchdog counts on its own rc clock
// R2 - expiry while running resets the device
// R3 - expiry while asleep wakes, no reset
// R4 - any expiry clears the timeout flag
// R5 - fuse bit clear keeps watchdog off
// R6 - one scaler shared, option register selects
// R7 - clear or sleep zero watchdog count and postscaler, not the timer-side scaler
// R8 - clear leaves assignment and ratio alone
// R9 - sleep clears count, watchdog keeps running
// R10 - sleep clears powerdown, sets timeout flag
// R11 - sleep stops the main oscillator
// R12 - pins hold their state while asleep
// R13 - listed events end sleep
// R14 - reset pin resets, others just resume
// R15 - powerdown flag set at power up
// R16 - only async peripherals may wake
// R17 - main-clocked peripherals silent in sleep
// R18 - own enable wakes, global enable ignored
// R19 - global enable set vectors after wake
// R20 - pending interrupt makes sleep a no-op
// R21 - watchdog terminal count is a parameter
`timescale 1ns/100ps
module watchdog_sleep_wake_ctrl
    import wdt_sleep_pkg::*;
#(
    parameter int WDT_TERMINAL = wdt_sleep_pkg::WDT_BASE_COUNT
)
(
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // watchdog rc clock, free running
    input wire logic WDT_RC_CLK_IN,
    // fuse word, static
    input wire logic [7:0] FUSE_WORD_IN,
    // core instructions
    input wire logic CLEAR_WDT_INSTR_IN,
    input wire logic SLEEP_INSTR_IN,
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic TIMER_TICK_IN,
    // wake sources, raw from pins or async peripherals
    input wire logic EXT_RESET_PIN_N_IN,
    input wire logic EXT_IRQ_IN,
    input wire logic PORT_CHANGE_IN,
    input wire logic TIMER16_ASYNC_IRQ_IN,
    input wire logic CAPTURE_IRQ_IN,
    input wire logic CONVERTER_RC_IRQ_IN,
    input wire logic CONVERTER_RC_MODE_IN,
    input wire logic TIMER16_ASYNC_MODE_IN,
    // pin state to be frozen in sleep
    input wire logic [7:0] PIN_OUT_IN,
    input wire logic [7:0] PIN_OE_IN,
    // register port
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    // outputs
    output logic DEVICE_RESET_OUT,
    output logic MAIN_OSC_RUN_OUT,
    output logic WAKE_VECTOR_OUT,
    output logic TIMER_SCALED_TICK_OUT,
    output logic [7:0] PIN_OUT_OUT,
    output logic [7:0] PIN_OE_OUT
);
    import wdt_sleep_pkg::*;

    // ***************************************************************
    // registers and state
    // ***************************************************************
    logic [7:0] option_reg;
    logic [4:0] wake_en_reg;
    logic pd_n_reg;
    logic to_n_reg;
    logic wdt_rst_seen_reg;
    power_state_t state_reg;
    logic [2:0] rst_cnt_reg;
    logic [7:0] scaler_reg;
    logic [1:0] sync_external_reset_pin_n;
    logic wdt_en;
    logic scaler_on_wdt;
    logic [2:0] ratio;
    logic pending;
    logic clear_req;
    logic sleep_take;
    logic [4:0] src_sync;
    logic [4:0] src_a;

    function automatic logic ratio_hit(input logic [7:0] cnt, input logic [2:0] r,
                                       input logic wdt_side);
        logic [8:0] lim;
        lim = 9'h002 << r;
        if (wdt_side)
            lim = 9'h001 << r;
        ratio_hit = ({1'b0, cnt} + 9'h001) >= lim;
    endfunction : ratio_hit

    // R5 - fuse gates watchdog
    assign wdt_en = FUSE_WORD_IN[FUSE_WDT_EN_POS];
    // R6 - option selects scaler
    assign scaler_on_wdt = option_reg[SCALER_ASSIGN_POS];
    assign ratio = option_reg[RATIO_LSB_POS +: RATIO_WIDTH];

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    // raw wake sources; main-clock peripherals are not offered here
    // R16 - only async sources
    assign src_a = {CONVERTER_RC_IRQ_IN & CONVERTER_RC_MODE_IN, CAPTURE_IRQ_IN,
                    TIMER16_ASYNC_IRQ_IN & TIMER16_ASYNC_MODE_IN, PORT_CHANGE_IN,
                    EXT_IRQ_IN};
    logic [4:0] src_meta;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            src_meta <= 5'h00;
            src_sync <= 5'h00;
            sync_external_reset_pin_n <= 2'b11;
        end
        else
        begin
            src_meta <= src_a;
            src_sync <= src_meta;
            sync_external_reset_pin_n <= {sync_external_reset_pin_n[0], EXT_RESET_PIN_N_IN};
        end
    end

    // R18 - own enable only, global enable ignored for wake
    assign pending = |(src_sync & wake_en_reg);
    assign clear_req = CLEAR_WDT_INSTR_IN;
    // R20 - pending interrupt turns sleep into a no-op
    assign sleep_take = SLEEP_INSTR_IN && state_reg == ST_RUN && !pending;

    // ***************************************************************
    // watchdog rc domain
    // ***************************************************************
    // clear requests cross as a toggle so no pulse is lost
    logic clr_tog_reg;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            clr_tog_reg <= 1'b0;
        // R7 - clear and sleep zero count
        else if (clear_req || sleep_take)
            clr_tog_reg <= ~clr_tog_reg;
    end

    logic [2:0] rc_tog;
    logic [15:0] wdt_cnt_reg;
    logic [7:0] wdt_post_reg;
    logic expire_tog_reg;
    always_ff @(posedge WDT_RC_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            rc_tog <= 3'b000;
        else
            rc_tog <= {rc_tog[1:0], clr_tog_reg};
    end

    // R1 - own rc clock keeps counting while main clock sleeps
    // R21 - terminal count is a parameter
    always_ff @(posedge WDT_RC_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            wdt_cnt_reg <= 16'h0000;
            wdt_post_reg <= 8'h00;
            expire_tog_reg <= 1'b0;
        end
        // R9 - sleep clears count yet leaves it running
        else if (rc_tog[2] != rc_tog[1])
        begin
            wdt_cnt_reg <= 16'h0000;
            wdt_post_reg <= 8'h00;
        end
        // R5 - disabled by fuse, no runtime enable
        else if (wdt_en)
        begin
            if (wdt_cnt_reg == 16'(WDT_TERMINAL - 1))
            begin
                wdt_cnt_reg <= 16'h0000;
                // R6 - postscaler only when assigned
                if (!scaler_on_wdt || ratio_hit(wdt_post_reg, ratio, 1'b1))
                begin
                    wdt_post_reg <= 8'h00;
                    expire_tog_reg <= ~expire_tog_reg;
                end
                else
                    wdt_post_reg <= wdt_post_reg + 8'h01;
            end
            else
                wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
        end
    end

    // expiry toggle back to system clock; main clock runs in this model
    logic [2:0] exp_sync;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            exp_sync <= 3'b000;
        else
            exp_sync <= {exp_sync[1:0], expire_tog_reg};
    end
    logic expire;
    assign expire = exp_sync[2] != exp_sync[1];

    // ***************************************************************
    // shared scaler on the timer side
    // ***************************************************************
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            scaler_reg <= 8'h00;
            TIMER_SCALED_TICK_OUT <= 1'b0;
        end
        // R8 - only the count clears, not the option bits
        else if (scaler_on_wdt)
        begin
            scaler_reg <= 8'h00;
            TIMER_SCALED_TICK_OUT <= TIMER_TICK_IN;
        end
        else if (TIMER_TICK_IN)
        begin
            TIMER_SCALED_TICK_OUT <= ratio_hit(scaler_reg, ratio, 1'b0);
            scaler_reg <= ratio_hit(scaler_reg, ratio, 1'b0) ? 8'h00 : scaler_reg + 8'h01;
        end
        else
            TIMER_SCALED_TICK_OUT <= 1'b0;
    end

    // ***************************************************************
    // power state machine
    // ***************************************************************
    logic wake_any;
    assign wake_any = pending || expire;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            state_reg <= ST_RUN;
        else if (!sync_external_reset_pin_n[1] || rst_cnt_reg != 3'h0)
            state_reg <= ST_RUN;
        else
            unique case (state_reg)
                ST_RUN:
                    if (sleep_take)
                        state_reg <= ST_SLEEP;
                // R13 - wake events; R3 - expiry wakes here
                ST_SLEEP:
                    if (wake_any)
                        state_reg <= ST_WAKE;
                ST_WAKE:
                    state_reg <= ST_RUN;
                default:
                    state_reg <= ST_RUN;
            endcase
    end

    // device reset pulse: watchdog in run, or reset pin
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            rst_cnt_reg <= 3'h0;
            DEVICE_RESET_OUT <= 1'b1;
        end
        // R14 - reset pin always resets
        else if (!sync_external_reset_pin_n[1])
        begin
            rst_cnt_reg <= 3'(RESET_PULSE_CYCLES);
            DEVICE_RESET_OUT <= 1'b1;
        end
        // R2 - expiry in run resets
        else if (expire && state_reg == ST_RUN)
        begin
            rst_cnt_reg <= 3'(RESET_PULSE_CYCLES);
            DEVICE_RESET_OUT <= 1'b1;
        end
        else if (rst_cnt_reg != 3'h0)
        begin
            rst_cnt_reg <= rst_cnt_reg - 3'h1;
            DEVICE_RESET_OUT <= 1'b1;
        end
        else
            DEVICE_RESET_OUT <= 1'b0;
    end

    // ***************************************************************
    // status flags
    // ***************************************************************
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            // R15 - powerdown flag set at power up
            pd_n_reg <= 1'b1;
            to_n_reg <= 1'b1;
            wdt_rst_seen_reg <= 1'b0;
        end
        // R4 - expiry clears timeout flag, wins over sleep
        else if (expire)
        begin
            to_n_reg <= 1'b0;
            wdt_rst_seen_reg <= state_reg == ST_RUN;
            if (sleep_take)
                pd_n_reg <= 1'b0;
        end
        // R10 - sleep entry flags
        else if (sleep_take)
        begin
            pd_n_reg <= 1'b0;
            to_n_reg <= 1'b1;
        end
        else if (clear_req)
        begin
            pd_n_reg <= 1'b1;
            to_n_reg <= 1'b1;
        end
    end

    // R19 - vector request on wake when global enable set
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            WAKE_VECTOR_OUT <= 1'b0;
        else
            WAKE_VECTOR_OUT <= state_reg == ST_WAKE && GLOBAL_IRQ_ENABLE_IN && pending;
    end

    // R11 - oscillator stops in sleep; R17 - derived clocks stop too
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            MAIN_OSC_RUN_OUT <= 1'b1;
        else
            MAIN_OSC_RUN_OUT <= !(sleep_take || (state_reg == ST_SLEEP && !wake_any));
    end

    // R12 - pins frozen while asleep
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            PIN_OUT_OUT <= 8'h00;
            PIN_OE_OUT <= 8'h00;
        end
        else if (state_reg != ST_SLEEP && !sleep_take)
        begin
            PIN_OUT_OUT <= PIN_OUT_IN;
            PIN_OE_OUT <= PIN_OE_IN;
        end
    end

    // ***************************************************************
    // register port
    // ***************************************************************
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            option_reg <= OPTION_RESET;
            wake_en_reg <= WAKE_EN_RESET;
        end
        else if (REG_WR_IN && REG_ADDR_IN == ADDR_OPTION)
            option_reg <= REG_WDATA_IN;
        else if (REG_WR_IN && REG_ADDR_IN == ADDR_WAKE_EN)
            wake_en_reg <= REG_WDATA_IN[WAKE_SRC_COUNT-1:0];
    end

    // read data valid the cycle after the strobe; zero otherwise
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            REG_RDATA_OUT <= 8'h00;
        else if (!REG_RD_IN)
            REG_RDATA_OUT <= 8'h00;
        else
            unique case (REG_ADDR_IN)
                ADDR_OPTION: REG_RDATA_OUT <= option_reg;
                ADDR_FUSE: REG_RDATA_OUT <= FUSE_WORD_IN;
                ADDR_STATUS: REG_RDATA_OUT <= {4'h0, wdt_rst_seen_reg,
                                               state_reg == ST_SLEEP, to_n_reg, pd_n_reg};
                ADDR_WAKE_EN: REG_RDATA_OUT <= {3'h0, wake_en_reg};
                default: REG_RDATA_OUT <= 8'h00;
            endcase
    end

endmodule : watchdog_sleep_wake_ctrl

/* sim/core_model.sv */
`timescale 1ns/100ps
module core_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // requests from the bench
    input wire logic kick_en_in,
    input wire logic sleep_req_in,
    input wire logic osc_run_in,
    // instruction strobes
    output logic clear_out,
    output logic sleep_out
);
    // *************************************
    // core issuing clear and sleep
    // *************************************
    logic [1:0] gap_reg;

    // a stopped core executes nothing, so clears halt while asleep
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gap_reg <= 2'h0;
            clear_out <= 1'h0;
            sleep_out <= 1'h0;
        end
        else
        begin
            gap_reg <= gap_reg + 2'h1;
            sleep_out <= sleep_req_in && osc_run_in;
            // one instruction a cycle, sleep wins
            clear_out <= kick_en_in && osc_run_in && !sleep_req_in && gap_reg == 2'h3;
        end
    end
endmodule : core_model

/* sim/watchdog_sleep_wake_ctrl_assertions.sv */
`timescale 1ns/100ps
module wdt_sleep_checker
    import wdt_sleep_pkg::*;
#(
    parameter int WDT_TERMINAL = WDT_BASE_COUNT
)
(
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // watched inputs
    input wire logic [7:0] FUSE_WORD_IN,
    input wire logic SLEEP_INSTR_IN,
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic EXT_RESET_PIN_N_IN,
    input wire logic EXT_IRQ_IN,
    input wire logic PORT_CHANGE_IN,
    input wire logic TIMER16_ASYNC_IRQ_IN,
    input wire logic CAPTURE_IRQ_IN,
    input wire logic CONVERTER_RC_IRQ_IN,
    // watched outputs
    input wire logic DEVICE_RESET_OUT,
    input wire logic MAIN_OSC_RUN_OUT,
    input wire logic WAKE_VECTOR_OUT,
    input wire logic [7:0] PIN_OUT_OUT,
    input wire logic [7:0] PIN_OE_OUT
);
    // *************************************
    // helper history and checks
    // *************************************
    logic [3:0] pin_hi_cnt;
    logic [3:0] src_lo_cnt;
    logic [3:0] off_cnt;
    logic src_any;

    assign src_any = EXT_IRQ_IN | PORT_CHANGE_IN | TIMER16_ASYNC_IRQ_IN | CAPTURE_IRQ_IN
        | CONVERTER_RC_IRQ_IN;

    // saturating quiet counts; sources pass a sync, so history matters
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            pin_hi_cnt <= 4'h0;
            src_lo_cnt <= 4'h0;
            off_cnt <= 4'h0;
        end
        else
        begin
            pin_hi_cnt <= !EXT_RESET_PIN_N_IN ? 4'h0 : pin_hi_cnt + {3'h0, pin_hi_cnt != 4'hF};
            src_lo_cnt <= src_any ? 4'h0 : src_lo_cnt + {3'h0, src_lo_cnt != 4'hF};
            off_cnt <= (FUSE_WORD_IN[FUSE_WDT_EN_POS] || !EXT_RESET_PIN_N_IN) ? 4'h0 :
                off_cnt + {3'h0, off_cnt != 4'hF};
        end
    end

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    a_sleep_stops_osc: assert property (
        SLEEP_INSTR_IN && !src_any && src_lo_cnt > 4'h3 && pin_hi_cnt > 4'h3
        && MAIN_OSC_RUN_OUT && $past(MAIN_OSC_RUN_OUT) && !DEVICE_RESET_OUT
        |=> !MAIN_OSC_RUN_OUT)
        else $error("oscillator still running after sleep");
    a_pins_held: assert property (
        !MAIN_OSC_RUN_OUT && !$past(MAIN_OSC_RUN_OUT) && !$past(MAIN_OSC_RUN_OUT, 2)
        |-> $stable(PIN_OUT_OUT) && $stable(PIN_OE_OUT))
        else $error("pin state moved while asleep");
    a_vector_after_wake: assert property (
        WAKE_VECTOR_OUT |-> !$past(MAIN_OSC_RUN_OUT, 2) && $past(GLOBAL_IRQ_ENABLE_IN))
        else $error("vector pulse without a wake");
    a_vector_needs_gie: assert property (
        !GLOBAL_IRQ_ENABLE_IN && !$past(GLOBAL_IRQ_ENABLE_IN) |-> !WAKE_VECTOR_OUT)
        else $error("vector pulse with global enable clear");
    a_reset_pulse_len: assert property (
        $rose(DEVICE_RESET_OUT) |-> DEVICE_RESET_OUT [*5])
        else $error("device reset pulse too short");
    a_pin_reset: assert property (
        $fell(EXT_RESET_PIN_N_IN) |-> ##[1:4] DEVICE_RESET_OUT)
        else $error("reset pin did not reset the device");
    a_sleep_no_reset: assert property (
        !MAIN_OSC_RUN_OUT && pin_hi_cnt > 4'h3 |=> !DEVICE_RESET_OUT)
        else $error("device reset raised from sleep");
    a_fuse_off_quiet: assert property (
        off_cnt > 4'h7 |-> !DEVICE_RESET_OUT)
        else $error("device reset with watchdog fused off");
endmodule : wdt_sleep_checker

bind watchdog_sleep_wake_ctrl wdt_sleep_checker #(.WDT_TERMINAL(WDT_TERMINAL)) chk (.*);

/* sim/watchdog_sleep_wake_ctrl_tb.sv */
`timescale 1ns/100ps
module watchdog_sleep_wake_ctrl_tb;
    import wdt_sleep_pkg::*;
    // *************************************
    // stimulus, monitors and scenarios
    // *************************************
    logic sys_clk = 1'h0, rc_clk = 1'h0, rst_b = 1'h0, kick_en = 1'h0, sleep_req = 1'h0;
    logic global_irq_enable = 1'h0, tick = 1'h0, rst_pin_n = 1'h1, wr = 1'h0, rd = 1'h0;
    logic [7:0] fuse = 8'h00, pin_o = 8'h3C, pin_e = 8'hF0, wdata = 8'h00;
    logic [4:0] irq = 5'h00;
    logic [1:0] mode = 2'h0; // bit0 converter on rc clock, bit1 timer16 async
    logic [3:0] addr = 4'h0;
    logic clr, slp, dev_rst, osc, vec, stick, rst_seen, vec_seen;
    logic [7:0] rdata, pout, poe;
    int sticks = 0, failures = 0, tests_run = 0;

    initial forever #5 sys_clk = ~sys_clk;
    // rc clock unrelated in phase to the system clock
    initial forever #18.3 rc_clk = ~rc_clk;

    // sticky records of pulses the scenarios look for
    always @(posedge sys_clk)
    begin
        if (dev_rst === 1'h1)
            rst_seen <= 1'h1;
        if (vec === 1'h1)
            vec_seen <= 1'h1;
        if (stick === 1'h1)
            sticks <= sticks + 1;
    end

    core_model core (.clk_in(sys_clk), .rst_b_in(rst_b), .kick_en_in(kick_en),
        .sleep_req_in(sleep_req), .osc_run_in(osc), .clear_out(clr), .sleep_out(slp));

    watchdog_sleep_wake_ctrl #(.WDT_TERMINAL(4)) DUT (.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b),
        .WDT_RC_CLK_IN(rc_clk), .FUSE_WORD_IN(fuse), .CLEAR_WDT_INSTR_IN(clr),
        .SLEEP_INSTR_IN(slp), .GLOBAL_IRQ_ENABLE_IN(global_irq_enable), .TIMER_TICK_IN(tick),
        .EXT_RESET_PIN_N_IN(rst_pin_n), .EXT_IRQ_IN(irq[0]), .PORT_CHANGE_IN(irq[1]),
        .TIMER16_ASYNC_IRQ_IN(irq[2]), .CAPTURE_IRQ_IN(irq[3]), .CONVERTER_RC_IRQ_IN(irq[4]),
        .CONVERTER_RC_MODE_IN(mode[0]), .TIMER16_ASYNC_MODE_IN(mode[1]), .PIN_OUT_IN(pin_o),
        .PIN_OE_IN(pin_e), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .DEVICE_RESET_OUT(dev_rst),
        .MAIN_OSC_RUN_OUT(osc), .WAKE_VECTOR_OUT(vec), .TIMER_SCALED_TICK_OUT(stick),
        .PIN_OUT_OUT(pout), .PIN_OE_OUT(poe));

    task automatic check_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge sys_clk);
        wr <= 1'h0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge sys_clk);
        rd <= 1'h0;
        #1;
        check_byte(what, exp, rdata);
    endtask : reg_chk

    // bounded wait on the oscillator (w=0) or device reset (w=1)
    task automatic wait_for(input bit w, input logic v, input int lim);
        int n;
        n = 0;
        while ((w ? dev_rst : osc) !== v && n < lim)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check_bit(w ? "device reset" : "osc run", v, w ? dev_rst : osc);
        if ((w ? dev_rst : osc) !== v)
            stop_test();
    endtask : wait_for

    task automatic do_sleep;
        @(posedge sys_clk);
        sleep_req <= 1'h1;
        @(posedge sys_clk);
        sleep_req <= 1'h0;
    endtask : do_sleep

    task automatic t_regs;
        reg_chk(ADDR_OPTION, OPTION_RESET, "option");
        reg_chk(ADDR_STATUS, 8'h03, "status");
        reg_chk(ADDR_WAKE_EN, 8'h00, "wake enable");
        reg_wr(ADDR_STATUS, 8'h00);
        reg_wr(ADDR_FUSE, 8'hFF);
        reg_chk(ADDR_STATUS, 8'h03, "status");
        reg_chk(ADDR_FUSE, fuse, "fuse");
        reg_chk(4'hF, 8'h00, "unmapped");
        // no postscaler: a watchdog that ignored the fuse would expire fast
        reg_wr(ADDR_OPTION, 8'h00);
        rst_seen = 1'h0;
        repeat (120) @(posedge sys_clk);
        check_bit("reset while fused off", 1'h0, rst_seen);
        $display("registers done");
    endtask : t_regs

    task automatic t_scaler;
        for (int k = 0; k < 2; k++)
        begin
            reg_wr(ADDR_OPTION, k ? 8'h0D : 8'h00);
            sticks = 0;
            repeat (8) @(posedge sys_clk) tick <= ~tick;
            repeat (4) @(posedge sys_clk);
            check_byte("scaled ticks", k ? 8'h04 : 8'h02, 8'(sticks));
        end
        kick_en <= 1'h1;
        repeat (6) @(posedge sys_clk);
        kick_en <= 1'h0;
        reg_chk(ADDR_OPTION, 8'h0D, "option after clear");
        $display("scaler done");
    endtask : t_scaler

    task automatic t_sleep_wake;
        @(posedge sys_clk);
        global_irq_enable <= 1'h1;
        reg_wr(ADDR_WAKE_EN, 8'h11);
        do_sleep();
        wait_for(0, 1'h0, 6);
        reg_chk(ADDR_STATUS, 8'h06, "status asleep");
        @(posedge sys_clk);
        pin_o <= 8'hC3;
        pin_e <= 8'h0F;
        irq <= 5'h10;
        repeat (10) @(posedge sys_clk);
        #1;
        check_bit("osc run", 1'h0, osc);
        check_byte("pins held", 8'h3C, pout);
        check_byte("enables held", 8'hF0, poe);
        vec_seen = 1'h0;
        // converter now runs on its rc clock, so its request may wake
        @(posedge sys_clk);
        mode <= 2'h1;
        wait_for(0, 1'h1, 8);
        repeat (4) @(posedge sys_clk);
        check_bit("wake vector", 1'h1, vec_seen);
        irq <= 5'h00;
        mode <= 2'h0;
        global_irq_enable <= 1'h0;
        reg_chk(ADDR_STATUS, 8'h02, "status awake");
        check_byte("pins follow", 8'hC3, pout);
        $display("sleep wake done");
    endtask : t_sleep_wake

    task automatic t_pending;
        @(posedge sys_clk);
        kick_en <= 1'h1;
        repeat (8) @(posedge sys_clk);
        kick_en <= 1'h0;
        reg_wr(ADDR_WAKE_EN, 8'h01);
        irq <= 5'h01;
        repeat (4) @(posedge sys_clk);
        do_sleep();
        repeat (6) @(posedge sys_clk);
        #1;
        check_bit("osc run", 1'h1, osc);
        reg_chk(ADDR_STATUS, 8'h03, "status no-op sleep");
        @(posedge sys_clk);
        irq <= 5'h00;
        $display("pending done");
    endtask : t_pending

    task automatic t_wdt_run;
        reg_wr(ADDR_OPTION, 8'h00);
        wait_for(1, 1'h1, 200);
        wait_for(1, 1'h0, 20);
        reg_chk(ADDR_STATUS, 8'h09, "status after expiry");
        $display("watchdog run done");
    endtask : t_wdt_run

    task automatic t_wdt_sleep;
        @(posedge sys_clk);
        kick_en <= 1'h1;
        reg_wr(ADDR_OPTION, 8'h00);
        repeat (30) @(posedge sys_clk);
        rst_seen = 1'h0;
        repeat (150) @(posedge sys_clk);
        check_bit("reset while cleared", 1'h0, rst_seen);
        kick_en <= 1'h0;
        do_sleep();
        wait_for(0, 1'h0, 6);
        vec_seen = 1'h0;
        wait_for(0, 1'h1, 200);
        repeat (4) @(posedge sys_clk);
        check_bit("reset from sleep", 1'h0, rst_seen);
        check_bit("wake vector", 1'h0, vec_seen);
        reg_chk(ADDR_STATUS, 8'h00, "status after wake");
        @(posedge sys_clk);
        rst_pin_n <= 1'h0;
        wait_for(1, 1'h1, 8);
        @(posedge sys_clk);
        rst_pin_n <= 1'h1;
        // let the reset pin property see its whole window before the end
        repeat (3) @(posedge sys_clk);
        $display("watchdog sleep done");
    endtask : t_wdt_sleep

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge sys_clk);
        t_regs();
        t_scaler();
        t_sleep_wake();
        t_pending();
        // fuse is static, so change it under a second reset
        fuse <= 8'h04;
        rst_b <= 1'h0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge sys_clk);
        t_wdt_run();
        t_wdt_sleep();
        stop_test();
    end
endmodule : watchdog_sleep_wake_ctrl_tb
